// [include/iatw_pkg.sv]
// shared constants and types for the interrupt and timer wake block
package iatw_pkg;
  localparam int IATW_NSRC = 6;
  localparam int IATW_PC_W = 12;
  localparam int IATW_TMR_W = 16;
  // source index doubles as priority, 0 is highest
  localparam int SRC_USB = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_TMR0 = 2;
  localparam int SRC_SPIA = 3;
  localparam int SRC_SPIB = 4;
  localparam int SRC_TMR1 = 5;
  // vector of source n is VEC_BASE + n * VEC_STEP
  localparam logic [IATW_PC_W-1:0] VEC_BASE = 12'h004;
  localparam logic [IATW_PC_W-1:0] VEC_STEP = 12'h004;
  // timer control byte layout
  localparam int TMR_ON_BIT = 4;
  localparam int TMR_EDGE_BIT = 3;
  localparam int TMR_MODE_LSB = 6;
  localparam logic [1:0] TMR_MODE_EVENT = 2'h1;
  localparam logic [1:0] TMR_MODE_TIMER = 2'h2;
  localparam logic [1:0] TMR_MODE_PULSE = 2'h3;
  // timer clock is the system clock divided by this many cycles
  localparam int TMR_DIV_CYC = 4;
  localparam logic [1:0] TMR_DIV_LAST = 2'(TMR_DIV_CYC - 1);
  // reset values and the count maximum
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [IATW_TMR_W-1:0] TMR_CNT_RST = 16'h0000;
  localparam logic [IATW_TMR_W-1:0] TMR_CNT_MAX = 16'hFFFF;
  localparam logic [IATW_NSRC-1:0] FLAGS_RST = 6'h00;

  typedef logic [IATW_NSRC-1:0] iatw_src_vec_t;

  typedef struct packed {
    logic [1:0] mode;
    logic rsv5;
    logic on;
    logic edge_fall;
    logic [2:0] presc;
  } iatw_tmr_ctrl_t;

  typedef struct packed {
    logic take;
    logic [IATW_PC_W-1:0] vector;
    logic [IATW_PC_W-1:0] push_pc;
  } iatw_core_req_t;
endpackage

// [core/iatw_sync.sv]
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module iatw_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_clk_en) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// [core/iatw_ctrl.sv]
// interrupt request and acceptance, timer 0, and timer 0 and timer 1 wake logic
`timescale 1ns/100ps
module iatw_ctrl
  import iatw_pkg::*;
(
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // event sources, same clock domain except the ext pin
  input wire logic i_usb_event,
  input wire logic i_spi_a_done,
  input wire logic i_spi_b_done,
  input wire logic i_tmr1_ovf,
  input wire logic i_ext_irq_pin,
  input wire logic i_ext_pin_is_input,
  // interrupt control
  input wire iatw_src_vec_t i_irq_enable,
  input wire logic i_gie_set,
  input wire logic i_gie_clr,
  input wire logic i_flag_wr,
  input wire iatw_src_vec_t i_flag_wdata,
  output logic o_global_irq_enable,
  output iatw_src_vec_t o_irq_flags,
  // processor core
  input wire logic i_phase_two_pulse,
  input wire logic i_stack_full,
  input wire logic [IATW_PC_W-1:0] i_next_pc,
  input wire logic i_reti,
  input wire logic [IATW_PC_W-1:0] i_stack_top,
  output iatw_core_req_t o_core_req,
  output logic o_pop,
  output logic [IATW_PC_W-1:0] o_resume_pc,
  // timer 0
  input wire logic i_tmr_ctrl_wr,
  input wire iatw_tmr_ctrl_t i_tmr_ctrl_wdata,
  output iatw_tmr_ctrl_t o_timer_zero_control,
  input wire logic i_tmr_read,
  input wire logic i_preload_wr,
  input wire logic [IATW_TMR_W-1:0] i_preload_wdata,
  output logic [IATW_TMR_W-1:0] o_tmr_count,
  input wire logic i_tmr_pin,
  input wire logic i_tmr_pin_is_input,
  input wire logic i_tmr_pull_high,
  output logic o_tmr_pull_en,
  // power-down wake
  input wire logic i_power_down,
  output logic o_wake
);

  // lowest index wins, which is the fixed priority order
  function automatic int first_set(input iatw_src_vec_t v);
    int idx;
    idx = 0;
    for (int k = IATW_NSRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = k;
      end
    end
    return idx;
  endfunction

  function automatic logic [IATW_PC_W-1:0] vec_of(input int idx);
    logic [IATW_PC_W-1:0] off;
    off = IATW_PC_W'(idx) * VEC_STEP;
    return VEC_BASE + off;
  endfunction

  // pins cross into the system clock first
  logic ext_low_s;
  logic tmr_pin_s;

  iatw_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    // ext pin goes in inverted so a cleared synchroniser means idle high, no false edge
    .i_async({!i_ext_irq_pin, i_tmr_pin}),
    .o_sync({ext_low_s, tmr_pin_s})
  );

  // ---------------- timer 0 ----------------
  iatw_tmr_ctrl_t ctrl_q;
  logic [IATW_TMR_W-1:0] cnt_q;
  logic [IATW_TMR_W-1:0] preload_q;
  logic [1:0] div_q;
  logic tick;
  logic pin_used;
  logic tmr_pin_prev_q;
  logic pin_edge;
  logic edge_pend_q;
  logic pulse_seen_q;
  logic pin_active;
  logic inhibit;
  logic count_en;
  logic pulse_done;
  logic tmr0_ovf;

  assign tick = (div_q == TMR_DIV_LAST);
  assign inhibit = i_tmr_read | i_preload_wr;
  assign pin_used = i_tmr_pin_is_input &
                    ((ctrl_q.mode == TMR_MODE_EVENT) |
                     (ctrl_q.mode == TMR_MODE_PULSE));
  assign o_tmr_pull_en = i_tmr_pull_high;
  assign pin_active = pin_used & (ctrl_q.edge_fall ? tmr_pin_s : !tmr_pin_s);
  assign pin_edge = pin_used &
                    (ctrl_q.edge_fall ? (tmr_pin_prev_q & !tmr_pin_s)
                                      : (!tmr_pin_prev_q & tmr_pin_s));

  // tick advances freely; the count itself is what gets inhibited
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 2'h0;
    end else if (i_clk_en) begin
      div_q <= tick ? 2'h0 : div_q + 2'h1;
    end
  end

  // an edge waits for the next timer tick before it counts
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_pin_prev_q <= 1'b0;
      edge_pend_q <= 1'b0;
    end else if (i_clk_en) begin
      tmr_pin_prev_q <= tmr_pin_s;
      if (pin_edge) begin
        edge_pend_q <= 1'b1;
      end else if (tick && !inhibit) begin
        edge_pend_q <= 1'b0;
      end
    end
  end

  always_comb begin
    count_en = 1'b0;
    pulse_done = 1'b0;
    if (ctrl_q.on && tick && !inhibit) begin
      unique case (ctrl_q.mode)
        TMR_MODE_TIMER: count_en = 1'b1;
        TMR_MODE_EVENT: count_en = edge_pend_q;
        TMR_MODE_PULSE: begin
          count_en = pin_active;
          pulse_done = pulse_seen_q & !pin_active;
        end
        default: count_en = 1'b0;
      endcase
    end
  end

  assign tmr0_ovf = count_en & (cnt_q == TMR_CNT_MAX);

  // count resets to TMR_CNT_RST; a preload written while stopped sets a new start
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= TMR_CNT_RST;
    end else if (i_clk_en) begin
      if (!ctrl_q.on && i_preload_wr) begin
        cnt_q <= i_preload_wdata;
      end else if (tmr0_ovf) begin
        cnt_q <= preload_q;
      end else if (count_en) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // a preload written while stopped also loads the count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preload_q <= TMR_CNT_RST;
    end else if (i_clk_en && i_preload_wr) begin
      preload_q <= i_preload_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tmr_count <= TMR_CNT_RST;
    end else if (i_clk_en && !ctrl_q.on && i_preload_wr) begin
      o_tmr_count <= i_preload_wdata;
    end else if (i_clk_en && i_tmr_read) begin
      o_tmr_count <= cnt_q;
    end
  end

  // pulse mode is one-shot: end of pulse drops the on bit
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= iatw_tmr_ctrl_t'(TMR_CTRL_RST);
      pulse_seen_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_tmr_ctrl_wr) begin
        ctrl_q <= i_tmr_ctrl_wdata;
        pulse_seen_q <= 1'b0;
      end else if (pulse_done) begin
        ctrl_q.on <= 1'b0;
        pulse_seen_q <= 1'b0;
      end else if (count_en && ctrl_q.mode == TMR_MODE_PULSE) begin
        pulse_seen_q <= 1'b1;
      end
    end
  end

  assign o_timer_zero_control = ctrl_q;

  // ---------------- requests and acceptance ----------------
  iatw_src_vec_t flags_q;
  iatw_src_vec_t hw_set;
  iatw_src_vec_t pend;
  iatw_src_vec_t take_mask;
  logic ext_prev_q;
  logic ext_fall;
  logic gie_q;
  logic accept;
  int take_idx;

  assign ext_fall = i_ext_pin_is_input & !ext_prev_q & ext_low_s;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      ext_prev_q <= ext_low_s;
    end
  end

  always_comb begin
    hw_set = '0;
    hw_set[SRC_USB] = i_usb_event;
    hw_set[SRC_EXT] = ext_fall;
    hw_set[SRC_TMR0] = tmr0_ovf;
    hw_set[SRC_SPIA] = i_spi_a_done;
    hw_set[SRC_SPIB] = i_spi_b_done;
    hw_set[SRC_TMR1] = i_tmr1_ovf;
  end

  assign pend = flags_q & i_irq_enable;
  assign take_idx = first_set(pend);
  // sampled only at the phase pulse, so anything since the last one is seen
  assign accept = i_phase_two_pulse & gie_q & (|pend) & !i_stack_full;

  always_comb begin
    take_mask = '0;
    if (accept) begin
      take_mask[take_idx] = 1'b1;
    end
  end

  // hardware set beats any clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= FLAGS_RST;
    end else if (i_clk_en) begin
      if (i_flag_wr) begin
        flags_q <= (i_flag_wdata & ~take_mask) | hw_set;
      end else begin
        flags_q <= (flags_q & ~take_mask) | hw_set;
      end
    end
  end

  // a software set in the acceptance cycle wins, allowing nesting
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gie_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_gie_set) begin
        gie_q <= 1'b1;
      end else if (accept || i_gie_clr) begin
        gie_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_req <= '0;
    end else if (i_clk_en) begin
      o_core_req.take <= accept;
      if (accept) begin
        o_core_req.push_pc <= i_next_pc;
        o_core_req.vector <= vec_of(take_idx);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pop <= 1'b0;
      o_resume_pc <= '0;
    end else if (i_clk_en) begin
      o_pop <= i_reti;
      if (i_reti) begin
        o_resume_pc <= i_stack_top;
      end
    end
  end

  // a flag already set means the overflow carries no news, so no wake
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
    end else if (i_clk_en) begin
      o_wake <= i_power_down &
                ((tmr0_ovf & !flags_q[SRC_TMR0]) |
                 (i_tmr1_ovf & !flags_q[SRC_TMR1]));
    end
  end

  assign o_global_irq_enable = gie_q;
  assign o_irq_flags = flags_q;

  // ---------------- checks ----------------
  a_gie_blocks_take: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && !gie_q) |=> !o_core_req.take)
    else $error("request taken with global enable low");

  a_stack_full_block: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_stack_full) |=> !o_core_req.take)
    else $error("request taken while stack full");

  a_masked_no_take: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && (flags_q & i_irq_enable) == '0) |=> !o_core_req.take)
    else $error("take with nothing enabled pending");

  a_take_push_pc: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && accept) |=>
      (o_core_req.take && o_core_req.push_pc == $past(i_next_pc) &&
       !flags_q[$past(take_idx)] | $past(hw_set[take_idx])))
    else $error("push pc or flag clear wrong on take");

  a_take_clears_gie: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && accept && !i_gie_set) |=> !gie_q)
    else $error("global enable not cleared on take");

  a_reti_pop: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_reti) |=> (o_pop && o_resume_pc == $past(i_stack_top)))
    else $error("return did not pop saved pc");

  a_ovf_sets_flag: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && tmr0_ovf) |=> flags_q[SRC_TMR0])
    else $error("timer overflow did not set flag");

  a_wake_suppress: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && tmr0_ovf && flags_q[SRC_TMR0] && !i_tmr1_ovf) |=> !o_wake)
    else $error("wake despite preset timer flags");

  a_ovf_wakes: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_power_down && tmr0_ovf && !flags_q[SRC_TMR0]) |=> o_wake)
    else $error("timer overflow in power-down did not wake");

  a_inhibit_holds: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && inhibit) |=>
      cnt_q == (($past(i_preload_wr) && !$past(ctrl_q.on)) ? $past(i_preload_wdata)
                                                            : $past(cnt_q)))
    else $error("count moved during read or preload write");

  a_stop_holds: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && !ctrl_q.on) |=>
      cnt_q == ($past(i_preload_wr) ? $past(i_preload_wdata) : $past(cnt_q)))
    else $error("count moved while timer stopped");
endmodule

// [verification/iatw_core_model.sv]
// processor core model: phase pulses, program counter and return stack
`timescale 1ns/100ps
module iatw_core_model
  import iatw_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // clock, reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // from bench and block
  input wire logic i_reti_req,
  input wire iatw_core_req_t i_core_req,
  input wire logic i_pop,
  input wire logic [IATW_PC_W-1:0] i_resume_pc,
  // to block
  output logic o_phase_two_pulse,
  output logic o_stack_full,
  output logic [IATW_PC_W-1:0] o_next_pc,
  output logic o_reti,
  output logic [IATW_PC_W-1:0] o_stack_top
);
  logic [IATW_PC_W-1:0] stk_q [DEPTH];
  logic [IATW_PC_W-1:0] pc_q;
  logic [1:0] div_q;
  int sp_q;
  assign o_stack_full = (sp_q == DEPTH);
  // an empty stack shows a moving pattern, never a stale entry
  assign o_stack_top = (sp_q > 0) ? stk_q[sp_q-1] : ~pc_q;
  assign o_next_pc = pc_q + 12'h001;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_q <= 12'h020;
      div_q <= 2'h0;
      sp_q <= 0;
      o_phase_two_pulse <= 1'b0;
      o_reti <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      o_phase_two_pulse <= (div_q == 2'h3);
      o_reti <= i_reti_req && (sp_q > 0);
      if (i_core_req.take) begin
        stk_q[sp_q] <= i_core_req.push_pc;
        sp_q <= sp_q + 1;
        pc_q <= i_core_req.vector;
      end else if (i_pop) begin
        sp_q <= sp_q - 1;
        pc_q <= i_resume_pc;
      end else if (o_phase_two_pulse) begin
        pc_q <= o_next_pc;
      end
    end
  end
endmodule

// [verification/tb_iatw_ctrl.sv]
// self-checking bench for the interrupt and timer wake block
`timescale 1ns/100ps
module tb_iatw_ctrl;
  import iatw_pkg::*;
  typedef struct packed {logic [2:0] src; logic [5:0] flg; logic [11:0] vec;} iatw_row_t;
  localparam iatw_row_t ROWS [6] = '{'{3'h0, 6'h01, 12'h004}, '{3'h1, 6'h02, 12'h008},
    '{3'h2, 6'h04, 12'h00C}, '{3'h3, 6'h08, 12'h010}, '{3'h4, 6'h10, 12'h014},
    '{3'h5, 6'h20, 12'h018}};
  logic clk, rst_n, usb, spia, spib, t1ovf, xpin, xin, gset, gclr, fwr, tcw, trd;
  logic tpin, tpin_in, pull, pdn, reti_req, gie, pop, pull_en, wake, ph, sfull, reti;
  logic ph_h1, pwr;
  iatw_src_vec_t en, fwd, flags;
  iatw_tmr_ctrl_t tcd, tctl;
  iatw_core_req_t req;
  logic [11:0] rpc, npc, stop, npc_h1;
  logic [15:0] tcnt, c1, c2, pwd;
  logic [11:0] pq [$];
  int error_cnt = 0;
  int cmp_count = 0;
  iatw_ctrl iatw_ctrl_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_usb_event(usb), .i_spi_a_done(spia), .i_spi_b_done(spib), .i_tmr1_ovf(t1ovf),
    .i_ext_irq_pin(xpin), .i_ext_pin_is_input(xin), .i_irq_enable(en), .i_gie_set(gset),
    .i_gie_clr(gclr), .i_flag_wr(fwr), .i_flag_wdata(fwd), .o_global_irq_enable(gie),
    .o_irq_flags(flags), .i_phase_two_pulse(ph), .i_stack_full(sfull), .i_next_pc(npc),
    .i_reti(reti), .i_stack_top(stop), .o_core_req(req), .o_pop(pop), .o_resume_pc(rpc),
    .i_tmr_ctrl_wr(tcw), .i_tmr_ctrl_wdata(tcd), .o_timer_zero_control(tctl),
    .i_tmr_read(trd), .i_preload_wr(pwr), .i_preload_wdata(pwd), .o_tmr_count(tcnt),
    .i_tmr_pin(tpin), .i_tmr_pin_is_input(tpin_in), .i_tmr_pull_high(pull),
    .o_tmr_pull_en(pull_en), .i_power_down(pdn), .o_wake(wake));
  iatw_core_model #(.DEPTH(2)) iatw_core_model_i (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_reti_req(reti_req), .i_core_req(req), .i_pop(pop), .i_resume_pc(rpc),
    .o_phase_two_pulse(ph), .o_stack_full(sfull), .o_next_pc(npc), .o_reti(reti),
    .o_stack_top(stop));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // history of what the block sampled at the accepting edge
  always @(negedge clk) begin
    npc_h1 <= npc;
    ph_h1 <= ph;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ev(input logic [2:0] s);
    cyc(1);
    case (s)
      3'h0: usb <= 1'b1;
      3'h1: xpin <= 1'b0;
      3'h2: begin
        fwr <= 1'b1;
        fwd <= 6'h04;
      end
      3'h3: spia <= 1'b1;
      3'h4: spib <= 1'b1;
      default: t1ovf <= 1'b1;
    endcase
    cyc(1);
    {usb, spia, spib, t1ovf, fwr} <= 5'h00;
    cyc(6);
    xpin <= 1'b1;
  endtask
  task automatic fw(input logic [5:0] d);
    cyc(1);
    fwr <= 1'b1;
    fwd <= d;
    cyc(1);
    fwr <= 1'b0;
  endtask
  task automatic gs(input logic [5:0] m);
    cyc(1);
    en <= m;
    gset <= 1'b1;
    cyc(1);
    gset <= 1'b0;
  endtask
  task automatic tk(input logic want, input logic [11:0] v, input string m);
    logic got;
    got = 1'b0;
    for (int k = 0; k < 24 && !got; k++) begin
      @(negedge clk);
      got = (req.take === 1'b1);
    end
    ck(got === want, m);
    if (got) begin
      ck(req.vector === v, m);
      ck(req.push_pc === npc_h1 && ph_h1 === 1'b1, m);
      ck(gie === 1'b0, m);
      pq.push_back(req.push_pc);
    end
  endtask
  task automatic ret();
    logic got;
    got = 1'b0;
    cyc(1);
    reti_req <= 1'b1;
    cyc(1);
    reti_req <= 1'b0;
    for (int k = 0; k < 6 && !got; k++) begin
      @(negedge clk);
      got = (pop === 1'b1);
    end
    ck(got, "pop");
    ck(rpc === pq.pop_back(), "resume pc");
  endtask
  task automatic wk(input logic want, input string m);
    logic got;
    got = 1'b0;
    cyc(1);
    t1ovf <= 1'b1;
    cyc(1);
    t1ovf <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      got = got | (wake === 1'b1);
    end
    ck(got === want, m);
  endtask
  task automatic tw(input logic [7:0] d);
    cyc(1);
    tcw <= 1'b1;
    tcd <= d;
    cyc(1);
    tcw <= 1'b0;
  endtask
  task automatic rd(output logic [15:0] v);
    cyc(1);
    trd <= 1'b1;
    cyc(1);
    trd <= 1'b0;
    @(negedge clk);
    v = tcnt;
  endtask
  task automatic pw(input logic [15:0] d, input int n);
    cyc(1);
    pwr <= 1'b1;
    pwd <= d;
    cyc(n);
    pwr <= 1'b0;
  endtask
  task automatic ww(input logic want, input string m);
    logic got;
    got = 1'b0;
    for (int k = 0; k < 48; k++) begin
      @(negedge clk);
      got = got | (wake === 1'b1);
    end
    ck(got === want, m);
  endtask
  initial begin
    {usb, spia, spib, t1ovf, gset, gclr, fwr, tcw, trd, tpin, pull, pdn, reti_req} = 13'h0000;
    {xpin, xin, tpin_in} = 3'h7;
    {en, fwd} = 12'h000;
    tcd = 8'h00;
    {pwr, pwd} = 17'h00000;
    rst_n = 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    @(negedge clk);
    ck(flags === 6'h00 && gie === 1'b0 && tctl === 8'h00 && tcnt === 16'h0000, "reset");
    for (int i = 0; i < 6; i++) begin
      ev(ROWS[i].src);
      @(negedge clk);
      ck(flags === ROWS[i].flg, "flag set");
      gs(ROWS[i].flg);
      tk(1'b1, ROWS[i].vec, "take source");
      ck(flags === 6'h00, "flag cleared");
      ret();
    end
    fw(6'h3F);
    gs(6'h3F);
    tk(1'b1, 12'h004, "priority");
    ck(flags === 6'h3E, "lower kept");
    gs(6'h30);
    tk(1'b1, 12'h014, "nested");
    gs(6'h3F);
    tk(1'b0, 12'h000, "stack full");
    ck(flags === 6'h2E, "held full");
    ret();
    tk(1'b1, 12'h008, "after pop");
    ret();
    ret();
    tk(1'b0, 12'h000, "global off");
    ck(flags === 6'h2C, "held off");
    gs(6'h13);
    tk(1'b0, 12'h000, "source off");
    cyc(1);
    gclr <= 1'b1;
    cyc(1);
    gclr <= 1'b0;
    fw(6'h00);
    cyc(1);
    {xin, xpin} <= 2'h0;
    cyc(8);
    {xin, xpin} <= 2'h3;
    @(negedge clk);
    ck(flags === 6'h00 && gie === 1'b0, "pin not input");
    cyc(1);
    pdn <= 1'b1;
    wk(1'b1, "wake");
    ck(flags === 6'h20, "ovf flag");
    wk(1'b0, "wake suppressed");
    cyc(1);
    pdn <= 1'b0;
    tw(8'h80);
    tw(8'h90);
    @(negedge clk);
    ck(tctl === 8'h90, "ctrl");
    rd(c1);
    cyc(40);
    rd(c2);
    ck(c2 - c1 >= 16'h0009 && c2 - c1 <= 16'h000B, "timer runs");
    tw(8'h80);
    rd(c1);
    cyc(40);
    rd(c2);
    ck(c2 === c1, "timer stops");
    tw(8'h90);
    cyc(1);
    trd <= 1'b1;
    cyc(2);
    @(negedge clk);
    c1 = tcnt;
    cyc(20);
    @(negedge clk);
    ck(tcnt === c1, "read inhibits");
    cyc(1);
    trd <= 1'b0;
    tw(8'h80);
    tw(8'h40);
    tw(8'h50);
    rd(c1);
    for (int k = 0; k < 8; k++) begin
      if (k == 5) rd(c2);
      if (k == 5) ck(c2 - c1 === 16'h0005, "events");
      if (k == 5) tpin_in <= 1'b0;
      cyc(12);
      tpin <= 1'b1;
      cyc(12);
      tpin <= 1'b0;
    end
    rd(c1);
    ck(c1 === c2, "pin not timer");
    cyc(1);
    pull <= 1'b1;
    @(negedge clk);
    ck(pull_en === 1'b1, "pull kept");
    cyc(1);
    pull <= 1'b0;
    @(negedge clk);
    ck(pull_en === 1'b0, "pull off");
    tw(8'h80);
    tw(8'h90);
    rd(c1);
    pw(16'h0000, 40);
    rd(c2);
    ck(c2 - c1 <= 16'h0001, "preload inhibits");
    tw(8'h80);
    pw(16'hFFF8, 1);
    @(negedge clk);
    ck(tcnt === 16'hFFF8, "preload loads count");
    fw(6'h00);
    cyc(1);
    pdn <= 1'b1;
    tw(8'h90);
    ww(1'b1, "timer wake");
    ck(flags === 6'h04, "timer flag");
    ww(1'b0, "timer wake suppressed");
    cyc(1);
    pdn <= 1'b0;
    tw(8'h80);
    pw(16'h0000, 1);
    tpin_in <= 1'b1;
    tw(8'hC8);
    tw(8'hD8);
    cyc(1);
    tpin <= 1'b1;
    cyc(40);
    tpin <= 1'b0;
    cyc(12);
    rd(c1);
    ck(c1 >= 16'h0009 && c1 <= 16'h000B && tctl.on === 1'b0, "pulse width");
    close_out();
  end
  initial begin
    #60000;
    error_cnt++;
    close_out();
  end
endmodule
